/* File: logic/can_ctl_pkg.sv */
// Purpose: Shared constants and types for the CAN filter, flag and power control block.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Flag bit positions are shared by flag and enable registers.
package can_ctl_pkg;
    localparam int ADDR_W  = 6;
    localparam int TX_BUFS = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MCTL0   = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_MCTL1   = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_BT0     = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_BT1     = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_RXFLG   = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_RXIEN   = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_TXFLG   = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_TXIEN   = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_FCTL    = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_RXERR   = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_TXERR   = 6'h28;
    localparam logic [ADDR_W-1:0] OFS_PATTERN = 6'h2C;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 6'h30;

    // Module control 0 fields
    localparam int MC0_SOFTRST  = 0;
    localparam int MC0_SLEEPRQ  = 1;
    localparam int MC0_SLEEPACK = 2;

    // Receive flag fields
    localparam int RF_FULL = 0;
    localparam int RF_OVR  = 1;
    localparam int RF_BOFF = 2;
    localparam int RF_TPAS = 3;
    localparam int RF_RPAS = 4;
    localparam int RF_TWRN = 5;
    localparam int RF_RWRN = 6;
    localparam int RF_WAKE = 7;

    // Filter control fields
    localparam int FC_HIT_LO  = 0;
    localparam int FC_MODE_LO = 4;

    // Error counter thresholds and resync length
    localparam logic [8:0] WARN_LIMIT    = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUSOFF_LIMIT  = 9'h0FF;
    localparam logic [3:0] RESYNC_BITS   = 4'hB;

    // Reset values
    localparam logic                 SOFTRST_RST = 1'b1;
    localparam logic [TX_BUFS-1:0]   TXE_RST     = 3'h7;
    localparam logic                 RECESSIVE   = 1'b1;

    typedef enum logic [1:0] {FILT_SINGLE, FILT_DUAL, FILT_QUAD, FILT_CLOSED} filt_mode_t;
    typedef enum logic [2:0] {ST_NORMAL, ST_SLEEP_WAIT, ST_SLEEP, ST_SOFT_RESET, ST_POWER_DOWN,
                              ST_RESYNC} ctl_state_t;
endpackage

/* File: logic/filter_byte_match.sv */
// Purpose: One maskable 8-bit identifier comparator of the acceptance filter bank.
// Assumes: A mask bit of one marks the matching identifier bit as ignored.
// Notes:   Purely combinational.
module filter_byte_match (
    // Pattern, mask and received byte
    input  wire logic [7:0] pattern,
    input  wire logic [7:0] mask,
    input  wire logic [7:0] idByte,
    // Result
    output logic            hit
);
    // Every bit equal or masked out
    assign hit = &(~(pattern ^ idByte) | mask);
endmodule

/* File: logic/can_filter_irq_power_ctl.sv */
// Purpose: CAN acceptance filter, flag/interrupt unit, config lock and low-power control.
// Assumes: Protocol engine on core_clk supplies frameDone, rxIdWord, counters and bitTick.
// Notes:   rxPin is asynchronous and passes a three-stage synchroniser.
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
module can_filter_irq_power_ctl
    import can_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]  address,
    input  wire logic               read,
    input  wire logic               write,
    input  wire logic [31:0]        writedata,
    output logic      [31:0]        readdata,
    output logic                    waitrequest,
    // Protocol engine
    input  wire logic               bitTick,
    input  wire logic               frameDone,
    input  wire logic [31:0]        rxIdWord,
    input  wire logic               txBusy,
    input  wire logic               rxBusy,
    input  wire logic [TX_BUFS-1:0] txDone,
    input  wire logic [8:0]         rxErrCnt,
    input  wire logic [8:0]         txErrCnt,
    input  wire logic               txBit,
    output logic                    engineActive,
    output logic                    abortAll,
    output logic                    busOffPause,
    output logic [TX_BUFS-1:0]      txRequest,
    output logic                    copyFront,
    output logic [7:0]              ctrl1Cfg,
    output logic [7:0]              bitTiming0Cfg,
    output logic [7:0]              bitTiming1Cfg,
    // Chip
    input  wire logic               cpuStop,
    // CAN pins
    input  wire logic               rxPin,
    output logic                    txPin,
    // Interrupts
    output logic                    wakeIrq,
    output logic                    errorIrq,
    output logic                    rxIrq,
    output logic                    txIrq
);
    ctl_state_t         state;
    filt_mode_t         filterMode;
    logic               ack;
    logic               softReset;
    logic               sleepRequest;
    logic               sleepAck;
    logic [31:0]        acceptPattern;
    logic [31:0]        acceptMask;
    logic [7:0]         rxFlags;
    logic [7:0]         rxIrqEn;
    logic [TX_BUFS-1:0] txEmpty;
    logic [TX_BUFS-1:0] txIrqEn;
    logic [1:0]         filterHit;
    logic               backFull;
    logic [1:0]         backHit;
    logic               rxS1;
    logic               rxS2;
    logic               rxS3;
    logic               rxLevel;
    logic [3:0]         recCnt;
    logic [31:0]        readMux;
    logic [3:0]         byteHit;
    logic [3:0]         hits;
    logic [1:0]         hitNum;

    // Bus handshake: one wait cycle, then the access completes
    assign waitrequest = (read | write) & ~ack;
    wire wrGo      = write & ack & (state != ST_POWER_DOWN);
    wire cfgWrite  = wrGo & softReset;
    wire powerDown = (state == ST_POWER_DOWN);

    always_ff @(posedge core_clk)
    begin
        if (reset)
            ack <= 1'b0;
        else
            ack <= (read | write) & ~ack;
    end

    // Read data captured in the wait cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
            readdata <= 32'h0000_0000;
        else if (read & ~ack)
            readdata <= readMux;
    end

    // Read multiplexer; error counters only visible here
    always_comb
    begin
        readMux = 32'h0000_0000;
        case (address)
            OFS_MCTL0:
            begin
                readMux[MC0_SOFTRST]  = softReset;
                readMux[MC0_SLEEPRQ]  = sleepRequest;
                readMux[MC0_SLEEPACK] = sleepAck;
            end
            OFS_MCTL1:   readMux = {24'h000000, ctrl1Cfg};
            OFS_BT0:     readMux = {24'h000000, bitTiming0Cfg};
            OFS_BT1:     readMux = {24'h000000, bitTiming1Cfg};
            OFS_RXFLG:   readMux = {24'h000000, rxFlags};
            OFS_RXIEN:   readMux = {24'h000000, rxIrqEn};
            OFS_TXFLG:   readMux = {29'h00000000, txEmpty};
            OFS_TXIEN:   readMux = {29'h00000000, txIrqEn};
            OFS_FCTL:
            begin
                readMux[FC_HIT_LO+:2]  = filterHit;
                readMux[FC_MODE_LO+:2] = filterMode;
            end
            OFS_RXERR:   readMux = {23'h000000, rxErrCnt};
            OFS_TXERR:   readMux = {23'h000000, txErrCnt};
            OFS_PATTERN: readMux = acceptPattern;
            OFS_MASK:    readMux = acceptMask;
            default:     readMux = 32'h0000_0000;
        endcase
    end

    // Locked configuration registers
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ctrl1Cfg      <= 8'h00;
            bitTiming0Cfg <= 8'h00;
            bitTiming1Cfg <= 8'h00;
            filterMode    <= FILT_SINGLE;
            acceptPattern <= 32'h0000_0000;
            acceptMask    <= 32'h0000_0000;
        end
        else if (cfgWrite)
        begin
            case (address)
                OFS_MCTL1:   ctrl1Cfg      <= writedata[7:0];
                OFS_BT0:     bitTiming0Cfg <= writedata[7:0];
                OFS_BT1:     bitTiming1Cfg <= writedata[7:0];
                OFS_FCTL:    filterMode    <= filt_mode_t'(writedata[FC_MODE_LO+:2]);
                OFS_PATTERN: acceptPattern <= writedata;
                OFS_MASK:    acceptMask    <= writedata;
                default:     ;
            endcase
        end
    end

    // Interrupt enables, writable in every state except power down
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rxIrqEn <= 8'h00;
            txIrqEn <= 3'h0;
        end
        else if (wrGo && address == OFS_RXIEN)
            rxIrqEn <= writedata[7:0];
        else if (wrGo && address == OFS_TXIEN)
            txIrqEn <= writedata[TX_BUFS-1:0];
    end

    // Rx pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rxS1    <= RECESSIVE;
            rxS2    <= RECESSIVE;
            rxS3    <= RECESSIVE;
            rxLevel <= RECESSIVE;
        end
        else
        begin
            rxS1 <= rxPin;
            rxS2 <= rxS1;
            rxS3 <= rxS2;
            if (rxS2 == rxS3)
                rxLevel <= rxS3;
        end
    end
    wire busDominant = (rxS2 == rxS3) & (rxS3 != RECESSIVE) & (rxLevel == RECESSIVE);

    // Acceptance filter bank, one comparator per pattern byte
    genvar k;
    generate
        for (k = 0; k < 4; k++)
        begin : g_byte
            logic [7:0] idByte;
            assign idByte = (filterMode == FILT_SINGLE) ? rxIdWord[8*k+:8] :
                            (filterMode == FILT_DUAL)   ? rxIdWord[8*(k%2)+:8] :
                                                          rxIdWord[7:0];
            filter_byte_match u_match (
                .pattern (acceptPattern[8*k+:8]),
                .mask    (acceptMask[8*k+:8]),
                .idByte  (idByte),
                .hit     (byteHit[k])
            );
        end
    endgenerate

    // Filter hits per mode
    always_comb
    begin
        case (filterMode)
            FILT_SINGLE: hits = {3'b000, &byteHit};
            FILT_DUAL:   hits = {2'b00, byteHit[3] & byteHit[2], byteHit[1] & byteHit[0]};
            FILT_QUAD:   hits = byteHit;
            default:     hits = 4'h0;
        endcase
    end
    // Lowest filter wins
    assign hitNum = hits[0] ? 2'd0 : hits[1] ? 2'd1 : hits[2] ? 2'd2 : 2'd3;

    // Receive events
    wire acceptEvt  = frameDone & engineActive & (|hits);
    wire copyOk     = (state != ST_SLEEP) & (state != ST_POWER_DOWN) & ~softReset;
    wire copyEvt    = backFull & ~rxFlags[RF_FULL] & copyOk;
    wire overrunEvt = acceptEvt & backFull & ~copyEvt;
    wire wakeEvt    = busDominant & ((state == ST_SLEEP) | powerDown);

    // Background buffer occupancy; soft reset flushes it
    always_ff @(posedge core_clk)
    begin
        if (reset || softReset)
        begin
            backFull <= 1'b0;
            backHit  <= 2'd0;
        end
        else if (acceptEvt && (!backFull || copyEvt))
        begin
            backFull <= 1'b1;
            backHit  <= hitNum;
        end
        else if (copyEvt)
            backFull <= 1'b0;
    end

    // Front buffer copy strobe and hit field
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            copyFront <= 1'b0;
            filterHit <= 2'd0;
        end
        else
        begin
            copyFront <= copyEvt;
            if (copyEvt)
                filterHit <= backHit;
        end
    end

    // Receive flag register: level causes re-set every cycle, so a clear only sticks once gone
    wire [7:0] rxFlagSet = {wakeEvt,
                            rxErrCnt >= WARN_LIMIT,
                            txErrCnt >= WARN_LIMIT,
                            rxErrCnt >  PASSIVE_LIMIT,
                            txErrCnt >  PASSIVE_LIMIT,
                            txErrCnt >  BUSOFF_LIMIT,
                            overrunEvt,
                            copyEvt};
    wire [7:0] rxFlagClr = (wrGo && address == OFS_RXFLG) ? writedata[7:0] : 8'h00;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            rxFlags <= 8'h00;
        else
            rxFlags <= rxFlagSet | (rxFlags & ~rxFlagClr);
    end

    // Transmit empty flags; writing one schedules the buffer
    wire [TX_BUFS-1:0] txFlagClr = (wrGo && address == OFS_TXFLG) ? writedata[TX_BUFS-1:0] : 3'h0;

    always_ff @(posedge core_clk)
    begin
        if (reset)
            txEmpty <= TXE_RST;
        else
            txEmpty <= txDone | (txEmpty & ~txFlagClr);
    end
    // Scheduled buffers go out only while on the bus
    assign txRequest = ~txEmpty & {TX_BUFS{engineActive}};

    // Module control 0: soft reset and sleep request
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            softReset    <= SOFTRST_RST;
            sleepRequest <= 1'b0;
        end
        else if (wrGo && address == OFS_MCTL0)
        begin
            softReset <= writedata[MC0_SOFTRST];
            if (writedata[MC0_SLEEPRQ] || sleepAck)
                sleepRequest <= writedata[MC0_SLEEPRQ];
        end
        else if (state == ST_SLEEP && busDominant)
            sleepRequest <= 1'b0;
    end

    // Mode controller
    always_ff @(posedge core_clk)
    begin
        if (reset)
            state <= ST_SOFT_RESET;
        else if (cpuStop)
            state <= ST_POWER_DOWN;
        else
        begin
            case (state)
                ST_NORMAL:
                    if (softReset)
                        state <= ST_SOFT_RESET;
                    else if (sleepRequest)
                        state <= (txBusy || rxBusy || ~&txEmpty) ? ST_SLEEP_WAIT : ST_SLEEP;
                ST_SLEEP_WAIT:
                    if (softReset)
                        state <= ST_SOFT_RESET;
                    else if (!txBusy && !rxBusy && &txEmpty)
                        state <= ST_SLEEP;
                ST_SLEEP:
                    if (softReset)
                        state <= ST_SOFT_RESET;
                    else if (busDominant || !sleepRequest)
                        state <= ST_RESYNC;
                ST_SOFT_RESET:
                    if (!softReset)
                        state <= ST_RESYNC;
                ST_POWER_DOWN:
                    state <= softReset ? ST_SOFT_RESET : ST_RESYNC;
                ST_RESYNC:
                    if (softReset)
                        state <= ST_SOFT_RESET;
                    else if (recCnt == RESYNC_BITS)
                        state <= ST_NORMAL;
                default:
                    state <= ST_SOFT_RESET;
            endcase
        end
    end

    // Recessive bit counter for bus resynchronisation
    always_ff @(posedge core_clk)
    begin
        if (reset || state != ST_RESYNC)
            recCnt <= 4'h0;
        else if (bitTick)
            recCnt <= (rxLevel == RECESSIVE) ? recCnt + 4'h1 : 4'h0;
    end

    // Mode outputs
    assign sleepAck     = (state == ST_SLEEP);
    assign engineActive = (state == ST_NORMAL) | (state == ST_SLEEP_WAIT);
    assign abortAll     = softReset | powerDown;
    assign busOffPause  = (state == ST_SLEEP);
    assign txPin        = engineActive ? txBit : RECESSIVE;

    // Interrupt outputs, level while an enabled flag stands; wakeIrq only while sleepAck is also set
    assign wakeIrq  = rxFlags[RF_WAKE] & rxIrqEn[RF_WAKE] & sleepAck;
    assign errorIrq = |(rxFlags[RF_RWRN:RF_OVR] & rxIrqEn[RF_RWRN:RF_OVR]);
    assign rxIrq    = rxFlags[RF_FULL] & rxIrqEn[RF_FULL];
    assign txIrq    = |(txEmpty & txIrqEn);

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_tx_recessive: assert property (!engineActive |-> txPin == RECESSIVE)
        else $error("tx pin not recessive while off line");
    a_closed_nofull: assert property ((filterMode == FILT_CLOSED) && frameDone |-> !acceptEvt)
        else $error("closed filter accepted a frame");
    a_hit_lowest: assert property (acceptEvt && !backFull && hits[0] |=> backHit == 2'd0)
        else $error("lowest filter not reported");
    a_overrun_set: assert property (acceptEvt && backFull && rxFlags[RF_FULL] |=> rxFlags[RF_OVR])
        else $error("overrun flag not set");
    a_warn_level: assert property (rxErrCnt >= WARN_LIMIT |=> rxFlags[RF_RWRN])
        else $error("receive warning missing");
    a_busoff_flag: assert property (txErrCnt > BUSOFF_LIMIT |=> rxFlags[RF_BOFF])
        else $error("bus-off flag missing");
    a_clear_blocked: assert property (rxFlags[RF_TPAS] && txErrCnt > PASSIVE_LIMIT && rxFlagClr[RF_TPAS]
                                      |=> rxFlags[RF_TPAS])
        else $error("flag cleared while cause holds");
    a_cfg_lock: assert property (wrGo && address == OFS_BT0 && !softReset |=> $stable(bitTiming0Cfg))
        else $error("bit timing changed while on line");
    a_sleep_ack: assert property (state == ST_NORMAL && sleepRequest && !softReset && !cpuStop
                                  && !txBusy && !rxBusy && &txEmpty |=> sleepAck)
        else $error("idle sleep not acknowledged");
    a_resync_wait: assert property ($rose(engineActive) && !reset |-> $past(state) == ST_RESYNC)
        else $error("rejoined bus without resync");
    a_irq_level: assert property (rxFlags[RF_FULL] && rxIrqEn[RF_FULL] |-> rxIrq ##1 (rxIrq || !rxFlags[RF_FULL]))
        else $error("receive interrupt dropped");

    c_quad_hit3: cover property (filterMode == FILT_QUAD && acceptEvt && hitNum == 2'd3);
    c_sleep_wake: cover property (sleepAck ##[1:50] state == ST_RESYNC);
    c_overrun: cover property (overrunEvt);
endmodule

/* File: verif/can_bus_node.sv */
// Purpose: Bus-side stand-in giving bit ticks, the receive pin and received frames.
// Assumes: Idle bus is recessive (pulled up); one bit tick every four clocks.
// Notes:   Frames and wake activity are started by its tasks.
module can_bus_node
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Engine side
    output logic             bitTick,
    output logic             frameDone,
    output logic [31:0]      rxIdWord,
    // Pin
    output logic             rxPin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] tickDiv;

    // Bit tick divider
    always_ff @(posedge core_clk)
    begin
        tickDiv <= reset ? 2'h0 : tickDiv + 2'h1;
    end
    assign bitTick = (tickDiv == 2'h3);

    // Idle bus
    initial
    begin
        frameDone = 1'b0;
        rxIdWord  = 32'h0;
        rxPin     = 1'b1;
    end

    // One valid frame, identifier dropped after
    task automatic send(input logic [31:0] id);
        frameDone <= 1'b1;
        rxIdWord  <= id;
        @(posedge core_clk);
        frameDone <= 1'b0;
        rxIdWord  <= ~id; // Stale value scrambled
        @(posedge core_clk);
    endtask

    // Short dominant burst
    task automatic dominant();
        rxPin <= 1'b0;
        repeat (8) @(posedge core_clk);
        rxPin <= 1'b1;
    endtask
endmodule

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench for the filter, flag and power control block.
// Assumes: One wait cycle per bus access; reads checked from a queue.
// Notes:   Quad filter mode with a partly masked byte; random error counts.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import can_ctl_pkg::*;
    logic              core_clk, reset, read, write, waitrequest, txBusy, rxBusy, txBit, cpuStop;
    logic              txPin, abortAll, bitTick, frameDone, rxPin, wakeIrq, errorIrq, rxIrq, txIrq;
    logic              engineActive, busOffPause, copyFront;
    logic [7:0]        ctrl1Cfg, bitTiming0Cfg, bitTiming1Cfg;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata, readdata, rxIdWord, expQ[$];
    logic [2:0]        txDone, txRequest;
    logic [8:0]        rxErrCnt, txErrCnt, rv;
    int                errorCnt = 0, cmpCount = 0, copyCnt = 0;

    can_filter_irq_power_ctl can_filter_irq_power_ctl_i (.core_clk, .reset, .address, .read, .write,
        .writedata, .readdata, .waitrequest, .bitTick, .frameDone, .rxIdWord, .txBusy, .rxBusy, .txDone,
        .rxErrCnt, .txErrCnt, .txBit, .engineActive, .abortAll, .busOffPause, .txRequest, .copyFront,
        .ctrl1Cfg, .bitTiming0Cfg, .bitTiming1Cfg, .cpuStop, .rxPin, .txPin, .wakeIrq, .errorIrq,
        .rxIrq, .txIrq);
    can_bus_node can_bus_node_i (.core_clk, .reset, .bitTick, .frameDone, .rxIdWord, .rxPin);

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic testDone();
        $display("Comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Avalon transfer held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        @(posedge core_clk);
        while (waitrequest !== 1'b0)
        begin
            @(posedge core_clk);
            n++;
            if (n > 20)
            begin
                errorCnt++;
                testDone();
            end
        end
        write <= 1'b0;
        read <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Read data checked at the completing edge
    always @(posedge core_clk)
    begin
        if (read === 1'b1 && waitrequest === 1'b0)
            cmp("readdata", expQ.pop_front(), readdata);
    end

    // Copy strobes counted as they pass
    always @(posedge core_clk)
    begin
        if (copyFront === 1'b1)
            copyCnt++;
    end

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge core_clk);
        errorCnt++;
        testDone();
    end

    // Main sequence
    initial
    begin
        {reset, read, write, address, writedata} = {1'b1, 40'h0};
        {txBusy, rxBusy, txDone, rxErrCnt, txErrCnt, txBit, cpuStop} = 25'h0;
        void'($urandom(23));
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        rd(OFS_MCTL0, 32'h1);
        rd(OFS_TXFLG, 32'h7);
        cmp("txPin", 32'h1, {31'h0, txPin});
        wr(OFS_RXIEN, 32'h7E);
        rxErrCnt <= 9'h060;
        txErrCnt <= 9'h100;
        repeat (3) @(posedge core_clk);
        rd(OFS_RXFLG, 32'h6C);
        cmp("errorIrq", 32'h1, {31'h0, errorIrq});
        wr(OFS_RXERR, 32'h0);
        rd(OFS_RXERR, 32'h60);
        wr(OFS_RXFLG, 32'hFF);
        rd(OFS_RXFLG, 32'h6C);
        rv = 9'($urandom_range(0, 95));
        rxErrCnt <= rv;
        txErrCnt <= 9'($urandom_range(0, 95));
        repeat (3) @(posedge core_clk);
        wr(OFS_RXFLG, 32'hFF);
        rd(OFS_RXFLG, 32'h0);
        rd(OFS_RXERR, {23'h0, rv});
        cmp("errorIrq", 32'h0, {31'h0, errorIrq});
        wr(OFS_PATTERN, 32'h7733_3522);
        wr(OFS_MASK, 32'h0000_0F00);
        wr(OFS_FCTL, 32'h20);
        wr(OFS_MCTL1, 32'h3C);
        wr(OFS_BT0, 32'h5A);
        wr(OFS_BT1, 32'hA5);
        cmp("ctrl1Cfg", 32'h3C, {24'h0, ctrl1Cfg});
        cmp("bitTiming0Cfg", 32'h5A, {24'h0, bitTiming0Cfg});
        cmp("bitTiming1Cfg", 32'hA5, {24'h0, bitTiming1Cfg});
        rd(OFS_PATTERN, 32'h7733_3522);
        wr(OFS_RXIEN, 32'h1);
        wr(OFS_TXIEN, 32'h1);
        cmp("txIrq", 32'h1, {31'h0, txIrq});
        wr(OFS_MCTL0, 32'h0);
        wr(OFS_PATTERN, 32'h0);
        rd(OFS_PATTERN, 32'h7733_3522);
        wr(OFS_BT0, 32'h0);
        cmp("bitTiming0Cfg", 32'h5A, {24'h0, bitTiming0Cfg});
        repeat (60) @(posedge core_clk);
        cmp("txPin", 32'h0, {31'h0, txPin});
        cmp("engineActive", 32'h1, {31'h0, engineActive});
        wr(OFS_TXFLG, 32'h1);
        cmp("txRequest", 32'h1, {29'h0, txRequest});
        cmp("txIrq", 32'h0, {31'h0, txIrq});
        txDone <= 3'h1;
        @(posedge core_clk);
        txDone <= 3'h0;
        @(posedge core_clk);
        cmp("txRequest", 32'h0, {29'h0, txRequest});
        cmp("txIrq", 32'h1, {31'h0, txIrq});
        can_bus_node_i.send({24'($urandom), 8'h33});
        repeat (3) @(posedge core_clk);
        rd(OFS_FCTL, 32'h21);
        rd(OFS_RXFLG, 32'h1);
        cmp("rxIrq", 32'h1, {31'h0, rxIrq});
        can_bus_node_i.send(32'h0000_0033);
        can_bus_node_i.send(32'h0000_0033);
        rd(OFS_RXFLG, 32'h3);
        wr(OFS_RXFLG, 32'h1);
        rd(OFS_RXFLG, 32'h3);
        cmp("copyCnt", 32'h2, copyCnt);
        wr(OFS_MCTL0, 32'h2);
        rd(OFS_MCTL0, 32'h6);
        cmp("busOffPause", 32'h1, {31'h0, busOffPause});
        cmp("engineActive", 32'h0, {31'h0, engineActive});
        cmp("txPin", 32'h1, {31'h0, txPin});
        can_bus_node_i.dominant();
        repeat (8) @(posedge core_clk);
        rd(OFS_RXFLG, 32'h83);
        rd(OFS_MCTL0, 32'h0);
        repeat (60) @(posedge core_clk);
        cpuStop <= 1'b1;
        repeat (2) @(posedge core_clk);
        cmp("txPin", 32'h1, {31'h0, txPin});
        cmp("abortAll", 32'h1, {31'h0, abortAll});
        wr(OFS_RXIEN, 32'h81);
        cpuStop <= 1'b0;
        rd(OFS_RXIEN, 32'h1);
        wr(OFS_RXIEN, 32'h81);
        repeat (60) @(posedge core_clk);
        wr(OFS_MCTL0, 32'h2);
        @(posedge core_clk);
        cmp("wakeIrq", 32'h1, {31'h0, wakeIrq});
        wr(OFS_MCTL0, 32'h0);
        @(posedge core_clk);
        cmp("wakeIrq", 32'h0, {31'h0, wakeIrq});
        wr(OFS_MCTL0, 32'h1);
        cmp("abortAll", 32'h1, {31'h0, abortAll});
        cmp("txPin", 32'h1, {31'h0, txPin});
        wr(OFS_FCTL, 32'h30);
        wr(OFS_MCTL0, 32'h0);
        wr(OFS_RXFLG, 32'hFF);
        repeat (60) @(posedge core_clk);
        can_bus_node_i.send(32'h0000_0033);
        repeat (3) @(posedge core_clk);
        rd(OFS_RXFLG, 32'h0);
        cmp("copyCnt", 32'h2, copyCnt);
        testDone();
    end
endmodule
